// [bench/odc_host.sv]
// Host serial master model for the output driver control.
// Assumes a pull-up on the readback line outside this model.
`timescale 1ns/100ps
module odc_host (
	output logic sclk,
	output logic strobe,
	output logic sdin,
	input wire logic sdo
);
	initial begin
		sclk = 1'b0;
		strobe = 1'b1;
		sdin = 1'b0;
	end
	task automatic levels(input logic c, input logic s, input logic d);
		sclk <= c;
		strobe <= s;
		sdin <= d;
	endtask
	task automatic frame(input logic [15:0] w, input int n,
		output logic [15:0] rd);
		rd = 16'h0;
		strobe = 1'b0;
		#13;
		for (int i = 0; i < n; i++) begin
			// Hold past the falling edge before the next bit
			#1 sdin = w[15 - i];
			#2 sclk = 1'b1;
			#3 rd = {rd[14:0], sdo};
			sclk = 1'b0;
		end
		#13 strobe = 1'b1;
		// Released data line must not look valid
		sdin = ~sdin;
		#300;
	endtask
endmodule

// [bench/odc_properties.sv]
// Checker on the ports of the output driver control top.
// Assumes bind into odc_top; every check runs on sys_clk.
`timescale 1ns/100ps
module odc_properties (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic serial_clock_or_output_gate,
	input wire logic frame_strobe_or_sense_select,
	input wire logic clear_pin,
	input wire logic clear_value_select,
	input wire logic short_circuit_fault,
	input wire logic over_temp_fault,
	input wire logic serial_out_or_short_alert_out,
	input wire logic serial_out_or_short_alert_oe_n,
	input wire logic fault_out,
	input wire logic fault_oe_n,
	input wire logic hardware_mode,
	input wire logic output_enable,
	input wire logic ext_sense_select,
	input wire logic clear_active,
	input wire logic clear_to_midscale,
	input wire logic [15:0] frame_word
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	chk_drain_only: assert property (
		!serial_out_or_short_alert_out && !fault_out)
		else $error("drain driven high");
	chk_clear_pin: assert property (
		$rose(clear_pin) |-> ##[1:4] clear_active)
		else $error("clear late");
	chk_midscale_sel: assert property (
		$rose(clear_value_select) |-> ##[1:4] clear_to_midscale)
		else $error("midscale late");
	chk_sw_fault: assert property (
		!hardware_mode && $rose(over_temp_fault) |-> ##[1:4] !fault_oe_n)
		else $error("fault late");
	chk_hw_alert: assert property (
		hardware_mode && $rose(short_circuit_fault) |->
		##[1:4] !serial_out_or_short_alert_oe_n)
		else $error("alert late");
	chk_hw_outen: assert property (
		hardware_mode && $rose(serial_clock_or_output_gate) |->
		##[1:4] output_enable)
		else $error("enable late");
	chk_hw_sense: assert property (
		hardware_mode && $rose(frame_strobe_or_sense_select) |->
		##[1:4] ext_sense_select)
		else $error("sense late");
	chk_reset_state: assert property (disable iff (1'b0)
		rst |-> frame_word == 16'h0 && fault_oe_n)
		else $error("reset state");
endmodule
bind odc_top odc_properties i_chk (.*);

// [bench/odc_top_tb.sv]
// Self-checking bench for the output driver serial and pin control.
// Assumes odc_host as serial master and pull-ups on both drains.
`timescale 1ns/100ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
	errors++; $display("BAD %s exp %h got %h", n, e, a); end end
module odc_top_tb;
	logic sys_clk, rst, control_mode_pin, clear_pin, clear_value_select;
	logic serial_out_or_short_alert_out, serial_out_or_short_alert_oe_n;
	logic fault_out, fault_oe_n, hardware_mode, output_enable;
	logic ext_sense_select, clear_active, clear_to_midscale;
	logic [3:0] range_select;
	logic [15:0] frame_word, rd, w, exp_w;
	logic [2:0] ad, flt;
	wire serial_clock_or_output_gate, frame_strobe_or_sense_select;
	wire serial_in_or_range_bit0, serial_out_or_short_alert_in;
	wire addr_bit2_or_range_bit1, addr_bit1_or_range_bit2;
	wire addr_bit0_or_range_bit3;
	wire open_circuit_fault, short_circuit_fault, over_temp_fault;
	int errors = 0;
	int num_checks = 0;
	int cyc = 0;
	assign {addr_bit2_or_range_bit1, addr_bit1_or_range_bit2,
		addr_bit0_or_range_bit3} = ad;
	assign {open_circuit_fault, short_circuit_fault, over_temp_fault} = flt;
	assign serial_out_or_short_alert_in = serial_out_or_short_alert_oe_n ?
		1'b1 : serial_out_or_short_alert_out;
	odc_top i_dut (.*);
	odc_host i_host (
		.sclk(serial_clock_or_output_gate),
		.strobe(frame_strobe_or_sense_select),
		.sdin(serial_in_or_range_bit0),
		.sdo(serial_out_or_short_alert_in)
	);
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Frames need about fifteen cycles each
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			report_and_stop();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic do_reset(input logic m);
		@(posedge sys_clk);
		rst <= 1'b1;
		control_mode_pin <= m;
		tick(16);
		rst <= 1'b0;
		tick(6);
	endtask
	// model keeps only addressed whole frames
	task automatic send(input logic [15:0] v, input int n);
		i_host.frame(v, n, rd);
		tick(6);
		if (n == 16 && v[15:13] == ad)
			exp_w = v;
	endtask
	initial begin
		// Deferred so the reset edge reaches every flop at time zero
		rst <= 1'b1;
		control_mode_pin = 1'b0;
		{clear_pin, clear_value_select} = 2'h0;
		flt = 3'h0;
		ad = 3'h0;
		exp_w = 16'h0;
		void'($urandom(32'hc5d6));
		do_reset(1'b0);
		`CHK("word", 16'h0, frame_word)
		`CHK("mode", 1'b0, hardware_mode)
		$display("reset test done");
		for (int i = 0; i < 12; i++) begin
			w = 16'($urandom);
			@(posedge sys_clk) ad <= i[0] ? w[15:13] : ~w[15:13];
			send(w, 16);
			`CHK("word", exp_w, frame_word)
			`CHK("range", exp_w[7:4], range_select)
			`CHK("outen", exp_w[9], output_enable)
			`CHK("sense", exp_w[8], ext_sense_select)
			`CHK("clr", exp_w[11], clear_active)
			`CHK("mid", exp_w[10], clear_to_midscale)
		end
		$display("frame test done");
		send({ad, 13'h0}, 15);
		`CHK("short frame", 1'b0, fault_oe_n)
		w = {ad, 13'h15a3};
		send(w, 16);
		// Readback enable reaches the link side one frame later
		send(w, 16);
		send({ad, 13'h0}, 16);
		`CHK("good frame", 1'b1, fault_oe_n)
		`CHK("readback", w, rd)
		for (int i = 0; i < 3; i++) begin
			@(posedge sys_clk) flt <= 3'(1 << i);
			tick(5);
			`CHK("fault", 1'b0, fault_oe_n)
		end
		@(posedge sys_clk) {clear_pin, clear_value_select} <= 2'h3;
		tick(5);
		`CHK("clr pin", 1'b1, clear_active)
		`CHK("mid pin", 1'b1, clear_to_midscale)
		@(posedge sys_clk) {clear_pin, clear_value_select, flt} <= 5'h0;
		tick(5);
		`CHK("clr off", 1'b0, clear_active)
		`CHK("fault off", 1'b1, fault_oe_n)
		$display("fault test done");
		do_reset(1'b1);
		`CHK("mode", 1'b1, hardware_mode)
		for (int i = 0; i < 8; i++) begin
			w = 16'($urandom);
			@(posedge sys_clk) begin
				ad <= w[2:0];
				flt <= {1'b0, w[6], 1'b0};
				i_host.levels(w[3], w[4], w[5]);
			end
			tick(5);
			`CHK("range", {w[0], w[1], w[2], w[5]}, range_select)
			`CHK("outen", w[3], output_enable)
			`CHK("sense", w[4], ext_sense_select)
			`CHK("alert", ~w[6], serial_out_or_short_alert_oe_n)
		end
		$display("hardware test done");
		report_and_stop();
	end
endmodule

// [hw/odc_pkg.sv]
// Constants for the output driver serial and pin control block.
// Assumes one 16-bit control frame layout shared by host and device.
package odc_pkg;

	// ----------------------------------------
	// Frame shape
	// ----------------------------------------
	localparam int FRAME_BITS = 16;
	localparam int CNT_W = 5;
	localparam logic [4:0] CNT_FULL = 5'h10;
	localparam logic [4:0] CNT_SAT = 5'h11;

	// ----------------------------------------
	// Field positions within the frame
	// ----------------------------------------
	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 13;
	localparam int READBACK_BIT = 12;
	localparam int SW_CLEAR_BIT = 11;
	localparam int SW_CLEAR_VALUE_SELECT_BIT = 10;
	localparam int SW_OUTEN_BIT = 9;
	localparam int SW_EXTSENSE_BIT = 8;
	localparam int RANGE_MSB = 7;
	localparam int RANGE_LSB = 4;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [3:0] RANGE_RESET = 4'h0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int SYS_CLK_HZ = 20000000;
	localparam int SYS_PERIOD_NS = 50;
	localparam int MAX_SCLK_HZ = 30000000;
	localparam int CLEAR_ACT_NS = 1000;
	// Longest time, rounded down, at least one cycle
	localparam int CLEAR_ACT_CYC = (CLEAR_ACT_NS / SYS_PERIOD_NS) < 1 ? 1 :
		(CLEAR_ACT_NS / SYS_PERIOD_NS);
	localparam int SYNC_LATENCY = 3;

	typedef enum logic {
		ODC_SOFTWARE,
		ODC_HARDWARE
	} odc_mode_type;

endpackage

// [hw/odc_top.sv]
// Serial port and pin control of an industrial output driver.
// Assumes a host serial master on the pins and a free-running sys_clk.
//
// Contract
// RULE1 - Sample serial input on falling clock
// RULE2 - Host keeps input stable at falling edge
// RULE3 - Serial output changes on rising clock
// RULE4 - Serial output only pulls low
// RULE5 - Strobe rise loads frame, updates output
// RULE6 - Serial clock up to thirty megahertz
// RULE7 - Clear forces zero or mid scale
// RULE8 - Clear is pin OR software bit
// RULE9 - Clear select is pin OR bit
// RULE10 - Three address pins select device
// RULE11 - Hardware mode range from four pins
// RULE12 - Hardware mode output is short alert
// RULE13 - Hardware mode strobe selects sense resistor
// RULE14 - Hardware mode clock pin gates output
// RULE15 - Mode pin low software, high hardware
// RULE16 - Host raises strobe after sixteen bits
// RULE17 - Fault pin low on any fault; code drives it in software mode only, released in hardware mode
// RULE18 - Reset returns all state to power-on
// RULE19 - Strobe low frames; high ignores clock
`timescale 1ns/100ps

module odc_top
	import odc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic serial_clock_or_output_gate,
	input wire logic frame_strobe_or_sense_select,
	input wire logic serial_in_or_range_bit0,
	input wire logic addr_bit2_or_range_bit1,
	input wire logic addr_bit1_or_range_bit2,
	input wire logic addr_bit0_or_range_bit3,
	input wire logic control_mode_pin,
	input wire logic clear_pin,
	input wire logic clear_value_select,
	input wire logic open_circuit_fault,
	input wire logic short_circuit_fault,
	input wire logic over_temp_fault,
	input wire logic serial_out_or_short_alert_in,
	output logic serial_out_or_short_alert_out,
	output logic serial_out_or_short_alert_oe_n,
	output logic fault_out,
	output logic fault_oe_n,
	output logic hardware_mode,
	output logic [3:0] range_select,
	output logic output_enable,
	output logic ext_sense_select,
	output logic clear_active,
	output logic clear_to_midscale,
	output logic [15:0] frame_word
);

	// Clear must act within its limit after the pin synchroniser
	if (CLEAR_ACT_CYC < SYNC_LATENCY + 1) begin : g_clear_too_slow
		$error("Clear path slower than its activation limit");
	end

	// ----------------------------------------
	// Link domain: shift register on falling edges
	// ----------------------------------------
	logic [15:0] shift_r;
	logic [15:0] shift_nxt;
	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;
	logic seen_tgl_r;
	logic frame_tgl_r;
	logic [15:0] latch_word_r;
	logic latch_ok_r;

	// Toggle from the strobe domain is held steady for a whole frame,
	// so a new frame is spotted by comparing it on the first edge.
	always_comb begin
		shift_nxt = shift_r;
		cnt_nxt = cnt_r;
		// RULE19 strobe gates shifting
		if (!frame_strobe_or_sense_select) begin
			// RULE1 sample on fall
			shift_nxt = {shift_r[14:0], serial_in_or_range_bit0};
			if (seen_tgl_r != frame_tgl_r)
				cnt_nxt = 5'h01;
			else if (cnt_r != CNT_SAT)
				cnt_nxt = cnt_r + 5'h01;
		end
	end

	// RULE6 runs on link clock
	// RULE18 reset clears link state
	always_ff @(negedge serial_clock_or_output_gate or posedge rst) begin
		if (rst) begin
			shift_r <= CTRL_RESET;
			cnt_r <= '0;
			seen_tgl_r <= 1'b0;
		end else begin
			shift_r <= shift_nxt;
			cnt_r <= cnt_nxt;
			if (!frame_strobe_or_sense_select)
				seen_tgl_r <= frame_tgl_r;
		end
	end

	// ----------------------------------------
	// Strobe edge: parallel load
	// ----------------------------------------
	// Serial clock is quiet by the strobe rise, so the word is stable.
	// RULE5 load on strobe rise
	always_ff @(posedge frame_strobe_or_sense_select or posedge rst) begin
		if (rst) begin
			latch_word_r <= CTRL_RESET;
			latch_ok_r <= 1'b0;
			frame_tgl_r <= 1'b0;
		end else begin
			latch_word_r <= shift_r;
			// RULE16 sixteen bits expected
			latch_ok_r <= (cnt_r == CNT_FULL) &&
				(seen_tgl_r == frame_tgl_r);
			frame_tgl_r <= ~frame_tgl_r;
		end
	end

	// ----------------------------------------
	// Link domain: readback on rising edges
	// ----------------------------------------
	logic rb_meta_r;
	logic rb_sync_r;
	logic sdo_low_r;
	logic sdo_low_nxt;
	logic readback_en_r;

	always_comb begin
		sdo_low_nxt = 1'b0;
		if (rb_sync_r && !frame_strobe_or_sense_select)
			sdo_low_nxt = !shift_r[15];
	end

	// RULE3 output changes on rise
	always_ff @(posedge serial_clock_or_output_gate or posedge rst) begin
		if (rst) begin
			rb_meta_r <= 1'b0;
			rb_sync_r <= 1'b0;
			sdo_low_r <= 1'b0;
		end else begin
			rb_meta_r <= readback_en_r;
			rb_sync_r <= rb_meta_r;
			sdo_low_r <= sdo_low_nxt;
		end
	end

	// ----------------------------------------
	// System domain: pin synchronisers
	// ----------------------------------------
	localparam int NSYNC = 12;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] meta_r;
	logic [NSYNC-1:0] sync_r;

	assign pin_raw = {frame_tgl_r, control_mode_pin, clear_pin,
		clear_value_select, frame_strobe_or_sense_select,
		serial_clock_or_output_gate, serial_in_or_range_bit0,
		addr_bit2_or_range_bit1, addr_bit1_or_range_bit2,
		addr_bit0_or_range_bit3, short_circuit_fault,
		open_circuit_fault | over_temp_fault};

	genvar g;
	generate
		for (g = 0; g < NSYNC; g++) begin : g_sync
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					meta_r[g] <= 1'b0;
					sync_r[g] <= 1'b0;
				end else begin
					meta_r[g] <= pin_raw[g];
					sync_r[g] <= meta_r[g];
				end
			end
		end
	endgenerate

	logic tgl_s, mode_s, clear_s, clear_value_select_s, strobe_s, sclk_s;
	logic [3:0] pins4_s;
	logic short_s, other_fault_s;

	assign {tgl_s, mode_s, clear_s, clear_value_select_s, strobe_s, sclk_s} =
		sync_r[11:6];
	assign pins4_s = sync_r[5:2];
	assign short_s = sync_r[1];
	assign other_fault_s = sync_r[0];

	// ----------------------------------------
	// System domain: mode, frame accept, control
	// ----------------------------------------
	function automatic logic addr_match(input logic [15:0] w,
		input logic [3:0] pins);
		addr_match = w[ADDR_MSB:ADDR_LSB] == pins[2:0];
	endfunction

	odc_mode_type mode_r;
	odc_mode_type mode_nxt;
	logic mode_held_r;
	logic mode_held_nxt;
	logic [1:0] settle_r;
	logic [1:0] settle_nxt;
	logic tgl_seen_r;
	logic [15:0] ctrl_r;
	logic [15:0] ctrl_nxt;
	logic if_err_r;
	logic if_err_nxt;
	logic readback_en_nxt;
	logic new_frame;

	assign new_frame = tgl_s != tgl_seen_r;

	always_comb begin
		mode_nxt = mode_r;
		settle_nxt = settle_r;
		if (settle_r != 2'(SYNC_LATENCY))
			settle_nxt = settle_r + 2'h1;
		mode_held_nxt = mode_held_r | (settle_r == 2'(SYNC_LATENCY - 1));
		ctrl_nxt = ctrl_r;
		if_err_nxt = if_err_r;
		readback_en_nxt = readback_en_r;
		// RULE15 mode caught after reset
		// Synchroniser holds reset zeros for two edges after release
		if (!mode_held_r && settle_r == 2'(SYNC_LATENCY - 1))
			mode_nxt = mode_s ? ODC_HARDWARE : ODC_SOFTWARE;
		if (new_frame && mode_held_r && mode_r == ODC_SOFTWARE) begin
			if (!latch_ok_r) begin
				if_err_nxt = 1'b1;
			// RULE10 address pins select device
			end else if (addr_match(latch_word_r, pins4_s)) begin
				ctrl_nxt = latch_word_r;
				readback_en_nxt = latch_word_r[READBACK_BIT];
				if_err_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mode_r <= ODC_SOFTWARE;
			mode_held_r <= 1'b0;
			settle_r <= 2'h0;
			tgl_seen_r <= 1'b0;
			ctrl_r <= CTRL_RESET;
			if_err_r <= 1'b0;
			readback_en_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			mode_held_r <= mode_held_nxt;
			settle_r <= settle_nxt;
			tgl_seen_r <= tgl_s;
			ctrl_r <= ctrl_nxt;
			if_err_r <= if_err_nxt;
			readback_en_r <= readback_en_nxt;
		end
	end

	// ----------------------------------------
	// System domain: output controls
	// ----------------------------------------
	logic hw;
	logic [3:0] range_nxt;
	logic outen_nxt, sense_nxt, clr_nxt, mid_nxt, fault_nxt, alert_nxt;
	logic [3:0] range_r;
	logic outen_r, sense_r, clr_r, mid_r, fault_r, alert_r;

	assign hw = mode_r == ODC_HARDWARE;

	always_comb begin
		range_nxt = ctrl_r[RANGE_MSB:RANGE_LSB];
		outen_nxt = ctrl_r[SW_OUTEN_BIT];
		sense_nxt = ctrl_r[SW_EXTSENSE_BIT];
		// RULE8 clear is pin OR bit
		clr_nxt = clear_s | (!hw & ctrl_r[SW_CLEAR_BIT]);
		// RULE9 select is pin OR bit
		mid_nxt = clear_value_select_s | (!hw & ctrl_r[SW_CLEAR_VALUE_SELECT_BIT]);
		// RULE17 general fault alert
		fault_nxt = !hw && (short_s || other_fault_s || if_err_r);
		alert_nxt = 1'b0;
		if (hw) begin
			// RULE11 range from pins
			range_nxt = {pins4_s[0], pins4_s[1], pins4_s[2], pins4_s[3]};
			// RULE14 clock pin gates output
			outen_nxt = sclk_s;
			// RULE13 strobe selects sense
			sense_nxt = strobe_s;
			// RULE12 short circuit alert
			alert_nxt = short_s;
		end
		if (!mode_held_r) begin
			range_nxt = RANGE_RESET;
			outen_nxt = 1'b0;
			sense_nxt = 1'b0;
			alert_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			range_r <= RANGE_RESET;
			outen_r <= 1'b0;
			sense_r <= 1'b0;
			clr_r <= 1'b0;
			mid_r <= 1'b0;
			fault_r <= 1'b0;
			alert_r <= 1'b0;
		end else begin
			range_r <= range_nxt;
			outen_r <= outen_nxt;
			sense_r <= sense_nxt;
			clr_r <= clr_nxt;
			mid_r <= mid_nxt;
			fault_r <= fault_nxt;
			alert_r <= alert_nxt;
		end
	end

	// ----------------------------------------
	// Pins and status outputs
	// ----------------------------------------
	// Alert is a sys_clk flop; readback a link flop, never both at once.
	// RULE4 open drain, low only
	assign serial_out_or_short_alert_out = 1'b0;
	assign serial_out_or_short_alert_oe_n = hw ? !alert_r : !sdo_low_r;
	assign fault_out = 1'b0;
	assign fault_oe_n = !fault_r;
	assign hardware_mode = hw;
	assign range_select = range_r;
	assign output_enable = outen_r;
	assign ext_sense_select = sense_r;
	// RULE7 clear forces chosen scale
	assign clear_active = clr_r;
	assign clear_to_midscale = mid_r;
	assign frame_word = ctrl_r;

endmodule
